/* src/smps_regs.svh */
// register offsets, field positions, reset values and timing figures of the scheduler
`ifndef SMPS_REGS_SVH
`define SMPS_REGS_SVH

// ----------------------------------------------------------------
// clock and bus address
// ----------------------------------------------------------------
`define SMPS_CLK_MHZ      100
`define SMPS_I2C_ADDR     7'h60

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SMPS_OFS_CHAN     8'h02
`define SMPS_OFS_PMODE    8'h27
`define SMPS_OFS_STATUS   8'h28

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SMPS_FILT_LSB     0
`define SMPS_FILT_MSB     2
`define SMPS_CHAN_LSB     6
`define SMPS_CHAN_MSB     8
`define SMPS_MODE_LSB     0
`define SMPS_MODE_MSB     1
`define SMPS_INACT_LSB    4
`define SMPS_INACT_MSB    6

// ----------------------------------------------------------------
// reset values and the highest filtered filter code
// ----------------------------------------------------------------
`define SMPS_FILT_RST     3'h0
`define SMPS_CHAN_RST     3'h7
`define SMPS_MODE_RST     2'h0
`define SMPS_INACT_RST    3'h0
`define SMPS_FIR_MAX      3'h2

// ----------------------------------------------------------------
// timing figures in microseconds; the tables are indexed by code
// ----------------------------------------------------------------
`define SMPS_INACT_US '{500, 1000, 5000, 10000, 50000, 100000, 500000, 1000000}
`define SMPS_ACT1_US  '{160, 80, 40, 0, 64, 32, 16, 0}
`define SMPS_ACT2_US  '{330, 170, 90, 0, 138, 74, 42, 0}
`define SMPS_ACT3_US  '{495, 255, 135, 0, 207, 111, 63, 0}
`define SMPS_POD_US   100

`endif

/* src/smps_pkg.sv */
// types shared by the sensor power mode scheduler
package smps_pkg;
  typedef enum logic [1:0] {MODE_ACTIVE, MODE_SLEEP, MODE_DUTY, MODE_RSVD} smps_mode_e;
  typedef enum logic [1:0] {PWR_SLEEP, PWR_WAKE, PWR_MEAS, PWR_IDLE} smps_pwr_e;
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_DEV, I2C_ADEV, I2C_REG, I2C_AREG, I2C_WR, I2C_AWR, I2C_RD, I2C_RACK
  } smps_i2c_e;
endpackage : smps_pkg

/* src/smps_timer.sv */
// loadable down counter that times each power phase
`timescale 1ns/10ps
`default_nettype none
module smps_timer #(
  parameter int unsigned W = 27
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic      [W-1:0] count,
  output logic              last
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // a load wins over counting; parks at zero so the phase logic never sees a wrap
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign count = cnt_reg;
  assign last  = (cnt_reg == {{(W-1){1'b0}}, 1'b1}); // final cycle of a loaded span
endmodule : smps_timer
`default_nettype wire

/* src/smps_regfile.sv */
// configuration registers and read multiplexer of the scheduler
`timescale 1ns/10ps
`include "smps_regs.svh"
`default_nettype none
module smps_regfile
  import smps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wr_en,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] status,
  output logic      [2:0]  chan_en,
  output logic      [2:0]  filt_code,
  output smps_mode_e       mode,
  output logic      [2:0]  inact_code,
  output logic      [31:0] rdata
);
  logic [2:0] chan_reg, chan_next;
  logic [2:0] filt_reg, filt_next;
  logic [1:0] mode_reg, mode_next;
  logic [2:0] inact_reg, inact_next;

  // writes land whatever phase is running; only defined fields are stored
  always_comb begin
    chan_next  = chan_reg;
    filt_next  = filt_reg;
    mode_next  = mode_reg;
    inact_next = inact_reg;
    if (wr_en && addr == `SMPS_OFS_CHAN) begin
      chan_next = wdata[`SMPS_CHAN_MSB:`SMPS_CHAN_LSB];
      filt_next = wdata[`SMPS_FILT_MSB:`SMPS_FILT_LSB];
    end
    if (wr_en && addr == `SMPS_OFS_PMODE) begin
      mode_next  = wdata[`SMPS_MODE_MSB:`SMPS_MODE_LSB];
      inact_next = wdata[`SMPS_INACT_MSB:`SMPS_INACT_LSB];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_reg  <= `SMPS_CHAN_RST;
      filt_reg  <= `SMPS_FILT_RST;
      mode_reg  <= `SMPS_MODE_RST;
      inact_reg <= `SMPS_INACT_RST;
    end else begin
      chan_reg  <= chan_next;
      filt_reg  <= filt_next;
      mode_reg  <= mode_next;
      inact_reg <= inact_next;
    end
  end

  // reserved bits and unmapped offsets read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (addr)
      `SMPS_OFS_CHAN: begin
        rdata[`SMPS_CHAN_MSB:`SMPS_CHAN_LSB] = chan_reg;
        rdata[`SMPS_FILT_MSB:`SMPS_FILT_LSB] = filt_reg;
      end
      `SMPS_OFS_PMODE: begin
        rdata[`SMPS_MODE_MSB:`SMPS_MODE_LSB]   = mode_reg;
        rdata[`SMPS_INACT_MSB:`SMPS_INACT_LSB] = inact_reg;
      end
      `SMPS_OFS_STATUS: rdata = status;
      default: rdata = 32'h0000_0000;
    endcase
  end

  assign chan_en    = chan_reg;
  assign filt_code  = filt_reg;
  assign mode       = smps_mode_e'(mode_reg);
  assign inact_code = inact_reg;

  a_mode_write: assert property (@(posedge clk) disable iff (!arst_n)
    wr_en && addr == `SMPS_OFS_PMODE |=> mode_reg == $past(wdata[1:0]))
    else $error("mode field did not take the written value");
endmodule : smps_regfile
`default_nettype wire

/* src/smps_top.sv */
// power mode scheduler with its serial register port
`timescale 1ns/10ps
`include "smps_regs.svh"
`default_nettype none
// How it works
// - two-bit mode selects active, sleep, duty-cycled
// - mode field readable and writable any time
// - sleep answers bus, produces no results
// - leaving sleep waits the power-on delay
// - duty mode alternates active and inactive phases
// - inactive length from three-bit interval field
// - interval codes map 0.5 to 1000 ms
// - active length from filter code, channel count
// - one enable bit per axis channel
// - code 0 takes 160/330/495 us
// - codes 1, 2 and 4-6 take their own update periods; 3 and 7 take code 0's
// - bus keeps working during inactive phase
// - filtering on for codes 0-2 only
module smps_top
  import smps_pkg::*;
#(
  parameter int unsigned INACT_US [8] = `SMPS_INACT_US,
  parameter int unsigned ACT1_US  [8] = `SMPS_ACT1_US,
  parameter int unsigned ACT2_US  [8] = `SMPS_ACT2_US,
  parameter int unsigned ACT3_US  [8] = `SMPS_ACT3_US,
  parameter int unsigned POD_US       = `SMPS_POD_US,
  parameter logic [6:0]  DEV_ADDR     = `SMPS_I2C_ADDR,
  parameter int unsigned TW           = 27
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            meas_active,
  output logic            result_update,
  output logic      [2:0] axis_convert,
  output logic            fir_enable
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  smps_i2c_e   i2c_st, i2c_next;
  logic [2:0]  bit_reg, bit_next;
  logic [7:0]  sh_reg, sh_next;
  logic        got_reg, got_next;
  logic        rw_reg, rw_next;
  logic        nack_reg, nack_next;
  logic [1:0]  byte_reg, byte_next;
  logic [7:0]  raddr_reg, raddr_next;
  logic [23:0] wbuf_reg, wbuf_next;
  logic [7:0]  tx_reg, tx_next;
  logic        scl_q, sda_q;
  logic        scl_rise, scl_fall, start, stop;
  logic        wr_en;
  logic [31:0] rdata, status;
  logic [7:0]  rd_byte;
  logic [2:0]  chan_en, filt_code, inact_code;
  smps_mode_e  mode;
  smps_pwr_e   pwr_st, pwr_next;
  logic        upd_reg, upd_next;
  logic [7:0]  rcnt_reg, rcnt_next;
  logic        tmr_load, tmr_last;
  logic [TW-1:0] tmr_val, tmr_cnt, act_cyc, inact_cyc;
  logic [1:0]  nch;

  // microseconds to clock cycles, never below one cycle
  function automatic logic [TW-1:0] us_cyc(input int unsigned us);
    int unsigned c;
    c = us * `SMPS_CLK_MHZ;
    if (c == 0) c = 1;
    return c[TW-1:0];
  endfunction : us_cyc

  // ----------------------------------------------------------------
  // serial register port
  // ----------------------------------------------------------------
  // pins are synchronous to clk, so one stage of history is enough for edges
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start    = scl_in & scl_q & sda_q & ~sda_in;
  assign stop     = scl_in & scl_q & ~sda_q & sda_in;
  assign rd_byte  = rdata[{~byte_reg, 3'b000} +: 8]; // most significant byte first
  // the port never looks at the power phase, so it answers in every mode
  assign wr_en    = scl_fall & got_reg & (i2c_st == I2C_WR) & (byte_reg == 2'd3);

  // bits are sampled on scl rise and driven on scl fall
  always_comb begin
    i2c_next   = i2c_st;
    bit_next   = bit_reg;
    sh_next    = sh_reg;
    got_next   = got_reg;
    rw_next    = rw_reg;
    nack_next  = nack_reg;
    byte_next  = byte_reg;
    raddr_next = raddr_reg;
    wbuf_next  = wbuf_reg;
    tx_next    = tx_reg;
    if (start) begin
      i2c_next = I2C_DEV;
      bit_next = 3'd0;
      got_next = 1'b0;
    end else if (stop) begin
      i2c_next = I2C_IDLE;
    end else if (scl_rise) begin
      case (i2c_st)
        I2C_DEV, I2C_REG, I2C_WR, I2C_RD: begin
          sh_next  = {sh_reg[6:0], sda_in};
          bit_next = bit_reg + 3'd1;
          got_next = (bit_reg == 3'd7);
        end
        I2C_RACK: nack_next = sda_in;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (i2c_st)
        I2C_DEV: if (got_reg) begin
          got_next  = 1'b0;
          rw_next   = sh_reg[0];
          byte_next = 2'd0;
          i2c_next  = (sh_reg[7:1] == DEV_ADDR) ? I2C_ADEV : I2C_IDLE;
        end
        I2C_ADEV: begin
          i2c_next = rw_reg ? I2C_RD : I2C_REG;
          tx_next  = rd_byte;
        end
        I2C_REG: if (got_reg) begin
          got_next   = 1'b0;
          raddr_next = sh_reg;
          i2c_next   = I2C_AREG;
        end
        I2C_AREG: i2c_next = I2C_WR;
        I2C_WR: if (got_reg) begin
          got_next  = 1'b0;
          wbuf_next = {wbuf_reg[15:0], sh_reg};
          i2c_next  = I2C_AWR;
        end
        I2C_AWR: begin
          i2c_next  = I2C_WR;
          byte_next = byte_reg + 2'd1;
          if (byte_reg == 2'd3) raddr_next = raddr_reg + 8'd1;
        end
        I2C_RD: begin
          if (got_reg) begin
            got_next  = 1'b0;
            i2c_next  = I2C_RACK;
            byte_next = byte_reg + 2'd1;
            if (byte_reg == 2'd3) raddr_next = raddr_reg + 8'd1;
          end else begin
            tx_next = {tx_reg[6:0], 1'b1};
          end
        end
        I2C_RACK: begin
          i2c_next = nack_reg ? I2C_IDLE : I2C_RD;
          tx_next  = rd_byte;
        end
        default: i2c_next = I2C_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      i2c_st    <= I2C_IDLE;
      bit_reg   <= 3'd0;
      sh_reg    <= 8'h00;
      got_reg   <= 1'b0;
      rw_reg    <= 1'b0;
      nack_reg  <= 1'b0;
      byte_reg  <= 2'd0;
      raddr_reg <= 8'h00;
      wbuf_reg  <= 24'h00_0000;
      tx_reg    <= 8'hff;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
    end else begin
      i2c_st    <= i2c_next;
      bit_reg   <= bit_next;
      sh_reg    <= sh_next;
      got_reg   <= got_next;
      rw_reg    <= rw_next;
      nack_reg  <= nack_next;
      byte_reg  <= byte_next;
      raddr_reg <= raddr_next;
      wbuf_reg  <= wbuf_next;
      tx_reg    <= tx_next;
      scl_q     <= scl_in;
      sda_q     <= sda_in;
    end
  end

  // open drain: only ever pulls low, ack slots or a zero data bit
  assign sda_out = 1'b0;
  assign sda_oe  = (i2c_st == I2C_ADEV) | (i2c_st == I2C_AREG) | (i2c_st == I2C_AWR)
                 | ((i2c_st == I2C_RD) & ~tx_reg[7]);

  assign status = {16'h0000, rcnt_reg, 6'h00, pwr_st};

  smps_regfile u_regs (
    .clk        (clk),
    .arst_n     (arst_n),
    .wr_en      (wr_en),
    .addr       (raddr_reg),
    .wdata      ({wbuf_reg, sh_reg}),
    .status     (status),
    .chan_en    (chan_en),
    .filt_code  (filt_code),
    .mode       (mode),
    .inact_code (inact_code),
    .rdata      (rdata)
  );

  // ----------------------------------------------------------------
  // phase lengths
  // ----------------------------------------------------------------
  // undefined filter codes fall back to the code 0 period of the same channel count
  always_comb begin
    nch = {1'b0, chan_en[0]} + {1'b0, chan_en[1]} + {1'b0, chan_en[2]};
    case (nch)
      2'd2: act_cyc = us_cyc((ACT2_US[filt_code] != 0) ? ACT2_US[filt_code] : ACT2_US[0]);
      2'd3: act_cyc = us_cyc((ACT3_US[filt_code] != 0) ? ACT3_US[filt_code] : ACT3_US[0]);
      default: act_cyc = us_cyc((ACT1_US[filt_code] != 0) ? ACT1_US[filt_code] : ACT1_US[0]);
    endcase
    inact_cyc = us_cyc(INACT_US[inact_code]);
  end

  assign fir_enable = (filt_code <= `SMPS_FIR_MAX);

  // ----------------------------------------------------------------
  // power phase machine
  // ----------------------------------------------------------------
  // phase lengths are sampled at each timer load, so their changes apply from the next phase
  always_comb begin
    pwr_next  = pwr_st;
    tmr_load  = 1'b0;
    tmr_val   = act_cyc;
    upd_next  = 1'b0;
    rcnt_next = rcnt_reg;
    if (mode == MODE_SLEEP || mode == MODE_RSVD) begin
      pwr_next = PWR_SLEEP;
    end else begin
      case (pwr_st)
        PWR_SLEEP: begin
          pwr_next = PWR_WAKE;
          tmr_load = 1'b1;
          tmr_val  = us_cyc(POD_US);
        end
        PWR_WAKE: if (tmr_last) begin
          pwr_next = PWR_MEAS;
          tmr_load = 1'b1;
        end
        PWR_MEAS: if (tmr_last) begin
          upd_next  = 1'b1;
          rcnt_next = rcnt_reg + 8'd1;
          tmr_load  = 1'b1;
          if (mode == MODE_DUTY) begin
            pwr_next = PWR_IDLE;
            tmr_val  = inact_cyc;
          end
        end
        PWR_IDLE: if (tmr_last || mode != MODE_DUTY) begin
          pwr_next = PWR_MEAS;
          tmr_load = 1'b1;
        end
        default: pwr_next = PWR_SLEEP;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_st   <= PWR_SLEEP;
      upd_reg  <= 1'b0;
      rcnt_reg <= 8'h00;
    end else begin
      pwr_st   <= pwr_next;
      upd_reg  <= upd_next;
      rcnt_reg <= rcnt_next;
    end
  end

  smps_timer #(.W(TW)) u_tmr (
    .clk      (clk),
    .arst_n   (arst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .count    (tmr_cnt),
    .last     (tmr_last)
  );

  // per-axis conversion strobes at the end of each active phase
  for (genvar gi = 0; gi < 3; gi++) begin : g_axis
    assign axis_convert[gi] = upd_reg & chan_en[gi];
  end

  assign meas_active   = (pwr_st == PWR_MEAS);
  assign result_update = upd_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_meas_end;
    pwr_st == PWR_MEAS && tmr_last && mode == MODE_DUTY;
  endsequence
  sequence s_idle_end;
    pwr_st == PWR_IDLE && tmr_last && mode == MODE_DUTY;
  endsequence

  a_sleep_no_result: assert property (pwr_st == PWR_SLEEP |=> !result_update)
    else $error("result produced while asleep");
  a_wake_pod_load: assert property (pwr_st == PWR_SLEEP && mode == MODE_ACTIVE
    |=> pwr_st == PWR_WAKE && tmr_cnt == us_cyc(POD_US))
    else $error("wake did not load the power-on delay");
  a_duty_to_idle: assert property (s_meas_end |=> pwr_st == PWR_IDLE && result_update
    && tmr_cnt == $past(inact_cyc))
    else $error("active phase did not hand over to inactive phase");
  a_idle_to_meas: assert property (s_idle_end |=> pwr_st == PWR_MEAS
    && tmr_cnt == $past(act_cyc))
    else $error("inactive phase did not start an active phase");
  a_idle_after_meas: assert property ($rose(pwr_st == PWR_IDLE) |-> $past(pwr_st) == PWR_MEAS)
    else $error("inactive phase entered without an active phase");
  a_inact_short: assert property ((inact_code == 3'd0) and s_meas_end
    |=> tmr_cnt == us_cyc(INACT_US[0]))
    else $error("shortest interval not loaded after active phase");
  a_act_code0: assert property (filt_code == 3'd0 && nch == 2'd3 && pwr_st == PWR_WAKE
    && tmr_last |=> tmr_cnt == us_cyc(ACT3_US[0]))
    else $error("three channel code 0 period wrong");
  a_fir_select: assert property (fir_enable == (filt_code inside {3'd0, 3'd1, 3'd2}))
    else $error("filter enable disagrees with filter code");
  a_axis_gate: assert property (|axis_convert |-> result_update && ((axis_convert & ~chan_en) == 3'd0))
    else $error("disabled axis converted");
  a_ack_drive: assert property (i2c_st == I2C_DEV && scl_fall && got_reg && !start && !stop
    && sh_reg[7:1] == DEV_ADDR |=> sda_oe)
    else $error("address not acknowledged");
endmodule : smps_top
`default_nettype wire

/* test/smps_host.sv */
// i2c host model that configures the scheduler and reads its registers
`timescale 1ns/10ps
`default_nettype none
module smps_host #(
  parameter logic [6:0] DEV = 7'h60
) (
  input  wire logic        clk,
  input  wire logic        sda_line,
  output logic             scl,
  output logic             sda_drv,
  output logic             rd_stb,
  output logic      [31:0] rd_word
);
  // bus idles high; sda is only pulled low, the bench adds the pull-up
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    rd_stb = 1'b0;
    rd_word = 32'h0000_0000;
  end
  // ------------------------------------------------------------
  // bit level: pins move only at falling clk edges
  // ------------------------------------------------------------
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask : hw
  // start and repeated start; scl stays high 8 clk, with sda falling after 4
  task automatic start_c();
    sda_drv = 1'b1;
    hw(2);
    scl = 1'b1;
    hw(4);
    sda_drv = 1'b0;
    hw(4);
    scl = 1'b0;
    hw(2);
  endtask : start_c
  task automatic stop_c();
    sda_drv = 1'b0;
    hw(2);
    scl = 1'b1;
    hw(4);
    sda_drv = 1'b1;
    hw(4);
  endtask : stop_c
  // one bit out and in: driving 1 releases the line for the device
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    hw(2);
    scl = 1'b1;
    hw(2);
    r = sda_line;
    hw(2);
    scl = 1'b0;
    hw(2);
  endtask : bit_io
  task automatic byte_io(input logic [7:0] b, input logic mack, output logic [7:0] r,
                         output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(mack, a);
    ack = !a;
  endtask : byte_io
  // ------------------------------------------------------------
  // register transfers, four bytes msb first
  // ------------------------------------------------------------
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [31:0] d,
                           output logic ok);
    logic [7:0] r;
    logic       a;
    start_c();
    byte_io({dev, 1'b0}, 1'b1, r, ok);
    if (ok) begin
      byte_io(ra, 1'b1, r, a);
      ok &= a;
      for (int i = 3; i >= 0; i--) begin
        byte_io(d[i*8+:8], 1'b1, r, a);
        ok &= a;
      end
    end
    stop_c();
  endtask : write_reg
  // the last byte is refused so the device lets go of the line
  task automatic read_reg(input logic [7:0] ra);
    logic [7:0] r;
    logic       a;
    start_c();
    byte_io({DEV, 1'b0}, 1'b1, r, a);
    byte_io(ra, 1'b1, r, a);
    start_c();
    byte_io({DEV, 1'b1}, 1'b1, r, a);
    for (int i = 3; i >= 0; i--) begin
      byte_io(8'hff, i == 0, r, a);
      rd_word[i*8+:8] = r;
    end
    stop_c();
    rd_stb = 1'b1;
    hw(1);
    rd_stb = 1'b0;
  endtask : read_reg
endmodule : smps_host
`default_nettype wire

/* test/sensor_power_mode_scheduler_tb.sv */
// self-checking bench of the sensor power mode scheduler
`timescale 1ns/10ps
`include "smps_regs.svh"
`default_nettype none
module sensor_power_mode_scheduler_tb;
  // short phase tables keep the run small; expectations use these
  localparam int unsigned INA [8] = '{1, 2, 3, 4, 5, 6, 7, 8};
  localparam int unsigned AC1 [8] = '{2, 3, 4, 0, 5, 6, 7, 0};
  localparam int unsigned AC2 [8] = '{3, 4, 5, 0, 6, 7, 8, 0};
  localparam int unsigned AC3 [8] = '{4, 5, 6, 0, 7, 8, 9, 0};
  localparam int unsigned POD     = 1;
  localparam int          CEIL    = 90000;
  localparam logic [2:0]  FC [6]  = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  logic        clk, arst_n, scl, sda_drv, sda_line, sda_out, sda_oe, rd_stb, ok;
  logic        meas_active, result_update, fir_enable, chk_axis;
  logic [2:0]  axis_convert, exp_axis, m, f;
  logic [31:0] rd_word;
  logic [63:0] mon_e;
  logic [63:0] exp_q [$];
  int          miscompares, checks, cyc, n;
  // open drain line with pull-up; the device pulls low when sda_oe is set and its data pin is 0
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
  smps_top #(
    .INACT_US (INA), .ACT1_US (AC1), .ACT2_US (AC2), .ACT3_US (AC3),
    .POD_US   (POD), .DEV_ADDR (`SMPS_I2C_ADDR), .TW (27)
  ) dut (
    .clk (clk), .arst_n (arst_n), .scl_in (scl), .sda_in (sda_line), .sda_out (sda_out),
    .sda_oe (sda_oe), .meas_active (meas_active), .result_update (result_update),
    .axis_convert (axis_convert), .fir_enable (fir_enable)
  );
  smps_host #(.DEV (`SMPS_I2C_ADDR)) host (
    .clk (clk), .sda_line (sda_line), .scl (scl), .sda_drv (sda_drv), .rd_stb (rd_stb),
    .rd_word (rd_word)
  );
  // ------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------
  task automatic cmp_logic(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_logic
  // cycle counts allow two clocks of pipeline slack
  task automatic cmp_cycles(input int got, input int exp);
    checks++;
    if (got < exp - 2 || got > exp + 2) begin
      miscompares++;
      $display("mismatch at %0t: %0d cycles expected %0d", $time, got, exp);
    end
  endtask : cmp_cycles
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic int act_cyc(input logic [2:0] fc, input logic [2:0] ch);
    int k;
    k = int'(ch[0]) + int'(ch[1]) + int'(ch[2]);
    return 100 * ((k == 1) ? AC1[fc] : (k == 2) ? AC2[fc] : AC3[fc]);
  endfunction : act_cyc
  task automatic wcfg(input logic [7:0] ra, input logic [31:0] d);
    logic a;
    host.write_reg(`SMPS_I2C_ADDR, ra, d, a);
    cmp_logic({31'h0, a}, 32'h0000_0001);
  endtask : wcfg
  // the note goes on the queue before the read starts
  task automatic expect_rd(input logic [7:0] ra, input logic [31:0] e, input logic [31:0] mk);
    exp_q.push_back({mk, e});
    host.read_reg(ra);
  endtask : expect_rd
  task automatic run_while(input logic lvl, output int c);
    c = 0;
    while (meas_active === lvl && c < 5000) begin
      @(negedge clk);
      c++;
    end
  endtask : run_while
  task automatic pulse_gap(output int c);
    c = 0;
    while (result_update !== 1'b1 && c < 5000) begin
      @(negedge clk);
      c++;
    end
    @(negedge clk);
    c = 1;
    while (result_update !== 1'b1 && c < 5000) begin
      @(negedge clk);
      c++;
    end
  endtask : pulse_gap
  // ------------------------------------------------------------
  // clock, watchdog and result monitor
  // ------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      miscompares++;
      print_verdict();
    end
  end
  // results are taken before the edge's updates land, so each pulse is seen once
  always @(posedge clk) begin
    if (rd_stb === 1'b1) begin
      mon_e = exp_q.pop_front();
      cmp_logic(rd_word & mon_e[63:32], mon_e[31:0]);
    end
    if (chk_axis && result_update === 1'b1) begin
      cmp_logic({29'h0, axis_convert}, {29'h0, exp_axis});
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h957a5a22));
    arst_n = 1'b0;
    chk_axis = 1'b0;
    exp_axis = 3'h7;
    cyc = 0;
    miscompares = 0;
    checks = 0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    cmp_logic({31'h0, fir_enable}, 32'h0000_0001);
    expect_rd(`SMPS_OFS_CHAN, 32'h0000_01c0, 32'h0000_01c7);
    expect_rd(`SMPS_OFS_PMODE, 32'h0000_0000, 32'h0000_0073);
    // wrong device address and unmapped offset are both ignored
    host.write_reg(7'h61, `SMPS_OFS_PMODE, 32'h0000_0001, ok);
    cmp_logic({31'h0, ok}, 32'h0000_0000);
    host.write_reg(`SMPS_I2C_ADDR, 8'h10, 32'hffff_ffff, ok);
    expect_rd(8'h10, 32'h0000_0000, 32'hffff_ffff);
    expect_rd(`SMPS_OFS_PMODE, 32'h0000_0000, 32'h0000_0073);
    // every defined filter code in continuous mode, random channel sets
    for (int i = 0; i < 6; i++) begin
      m = 3'($urandom_range(1, 7));
      chk_axis = 1'b0;
      wcfg(`SMPS_OFS_CHAN, {23'h0, m, 3'h0, FC[i]});
      exp_axis = m;
      chk_axis = 1'b1;
      cmp_logic({31'h0, fir_enable}, {31'h0, FC[i] <= 3'h2});
      expect_rd(`SMPS_OFS_CHAN, {23'h0, m, 3'h0, FC[i]}, 32'h0000_01c7);
      pulse_gap(n);
      pulse_gap(n);
      cmp_cycles(n, act_cyc(FC[i], m));
    end
    // sleep: bus still answers, nothing is measured
    wcfg(`SMPS_OFS_PMODE, 32'h0000_0001);
    expect_rd(`SMPS_OFS_PMODE, 32'h0000_0001, 32'h0000_0073);
    expect_rd(`SMPS_OFS_STATUS, 32'h0000_0000, 32'h0000_0003);
    n = 0;
    repeat (300) begin
      @(negedge clk);
      if (result_update !== 1'b0 || meas_active !== 1'b0) n++;
    end
    cmp_logic(32'(n), 32'h0000_0000);
    // the spare mode code also keeps the phase machine asleep
    wcfg(`SMPS_OFS_PMODE, 32'h0000_0003);
    expect_rd(`SMPS_OFS_STATUS, 32'h0000_0000, 32'h0000_0003);
    // wake: write returns 19.5 clk after the commit edge; measuring starts 101 clk after that edge
    wcfg(`SMPS_OFS_PMODE, 32'h0000_0000);
    run_while(1'b0, n);
    cmp_cycles(n, POD * 100 - 18);
    // duty cycling over every interval code; setup precedes the mode write
    for (int c = 0; c < 8; c++) begin
      m = 3'($urandom_range(1, 7));
      f = FC[$urandom_range(0, 5)];
      chk_axis = 1'b0;
      wcfg(`SMPS_OFS_CHAN, {23'h0, m, 3'h0, f});
      exp_axis = m;
      chk_axis = 1'b1;
      wcfg(`SMPS_OFS_PMODE, {25'h0, 3'(c), 4'h2});
      run_while(1'b0, n);
      run_while(1'b1, n);
      run_while(1'b0, n);
      cmp_cycles(n, INA[c] * 100);
      run_while(1'b1, n);
      cmp_cycles(n, act_cyc(f, m));
    end
    // bus traffic inside the longest inactive phase
    run_while(1'b1, n);
    expect_rd(`SMPS_OFS_PMODE, 32'h0000_0072, 32'h0000_0073);
    cmp_logic({31'h0, meas_active}, 32'h0000_0000);
    print_verdict();
  end
endmodule : sensor_power_mode_scheduler_tb
`default_nettype wire
